// >>> common/rsm_defs.vh
// Constants of the reset and supply monitor
// How it works
// - A boot option bit chooses the internal supply drop reset or the external reset pin as reset input.
// - Reset is entered on power-on, external pin low, watchdog timeout or supply drop reset.
// - The external reset input passes a two-stage synchronizer on the CPU clock before use.
// - A reset drives the reset pin low and loads every control register with its default.
// - A watchdog counter overflow without refresh asserts the internal reset.
// - The internal reset stays on while the supply drop comparator reports low and ends a hold of RSM_HOLD_CYC cycles after it clears.
// - Writing 1010 to the upper nibble of the basic timer control register disables the watchdog reset.
// - Bit 7 of the supply detect control register enables the supply level detector.
// - With the detector and its interrupt enabled, mask bit 0 set and the supply low, an interrupt request is raised.
// - Bit 5 of the supply detect control register reads 1 while the detector is enabled and the supply is low, and 0 otherwise.
// - The supply detect control register selects one of four detection levels.
`ifndef RSM_DEFS_VH
`define RSM_DEFS_VH
// --------------------------------
// Register byte offsets
// --------------------------------
`define RSM_OFS_SDC 5'h00
`define RSM_OFS_BTC 5'h04
`define RSM_OFS_STS 5'h08
`define RSM_OFS_MSK 5'h0C
`define RSM_OFS_CAU 5'h10
// --------------------------------
// Fields
// --------------------------------
`define RSM_SDC_EN 7
`define RSM_SDC_FLAG 5
`define RSM_SDC_IE 4
`define RSM_SDC_LVL_HI 1
`define RSM_SDC_LVL_LO 0
`define RSM_BTC_WDOFF 4'hA
`define RSM_BTC_WD_HI 7
`define RSM_BTC_WD_LO 4
`define RSM_BTC_CLR 1
// Status bits: 0 low supply, 1 watchdog reset seen, 2 supply drop reset seen
`define RSM_ST_LOW 0
`define RSM_ST_WDT 1
`define RSM_ST_DROP 2
// --------------------------------
// Reset values and timing
// --------------------------------
`define RSM_SDC_RST 8'h00
`define RSM_BTC_RST 8'h00
`define RSM_MSK_RST 3'h0
`define RSM_WDT_W 16
`define RSM_WDT_MAX 16'hFFFF
`define RSM_HOLD_NS 800
`define RSM_CLK_NS 50
// Release hold in clock cycles, 800 ns at 50 ns
`define RSM_HOLD_CYC 5'h10
`endif

// >>> verilog/rsm_sync2.v
// Two flip-flop level synchronizer
`timescale 1ns/1ps
`default_nettype none
module rsm_sync2 (
  input wire clk,
  input wire rst_val,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg stage1;
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= rst_val;
      q <= rst_val;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule // rsm_sync2
`default_nettype wire

// >>> verilog/rsm_wdt.v
// Watchdog counter on the CPU clock
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defs.vh"
module rsm_wdt (
  input wire clk,
  input wire rst_n,
  input wire enable,
  input wire refresh,
  output reg overflow
);
  reg [`RSM_WDT_W-1:0] count;
  always @(posedge clk) begin
    if (!rst_n) begin
      count <= {`RSM_WDT_W{1'b0}};
      overflow <= 1'b0;
    end else if (refresh || !enable) begin
      count <= {`RSM_WDT_W{1'b0}};
      overflow <= 1'b0;
    end else begin
      count <= count + 1'b1;
      overflow <= (count == `RSM_WDT_MAX);
    end
  end
endmodule // rsm_wdt
`default_nettype wire

// >>> verilog/rsm_top.v
// Reset sources, watchdog, supply detector and register slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defs.vh"
module rsm_top (
  input wire aclk,
  input wire aresetn,
  input wire power_on_n,
  input wire external_reset_n,
  input wire supply_drop_reset,
  input wire supply_level_detector,
  input wire boot_option_internal,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg reset_pin_low_active,
  output reg reset_pin_oe_n,
  output reg system_reset_n,
  output reg [1:0] detect_threshold,
  output reg detector_enable,
  output reg irq
);
  // --------------------------------
  // Synchronizers
  // --------------------------------
  wire [2:0] sync_in;
  wire [2:0] sync_out;
  wire ext_n_s;
  wire drop_s;
  wire low_s;
  assign sync_in = {supply_level_detector, supply_drop_reset, external_reset_n};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      // Pin input idles high, so its stages start high
      rsm_sync2 u_rsm_sync2 (.clk(aclk), .rst_val((gi == 0) ? 1'b1 : 1'b0), .rst_n(aresetn),
        .d(sync_in[gi]), .q(sync_out[gi]));
    end
  endgenerate
  assign ext_n_s = sync_out[0];
  assign drop_s = sync_out[1];
  assign low_s = sync_out[2];

  // --------------------------------
  // Registers
  // --------------------------------
  reg [7:0] supply_detect_control;
  reg [7:0] basic_timer_control;
  reg [2:0] status;
  reg [2:0] mask;
  reg [1:0] last_cause;
  reg [4:0] hold_cnt;
  reg boot_sel;
  reg boot_taken;
  reg wd_refresh;
  wire wd_over;
  wire wd_en;
  assign wd_en = (basic_timer_control[`RSM_BTC_WD_HI:`RSM_BTC_WD_LO] != `RSM_BTC_WDOFF);
  rsm_wdt u_wdt (.clk(aclk), .rst_n(aresetn && system_reset_n), .enable(wd_en),
    .refresh(wd_refresh), .overflow(wd_over));

  // --------------------------------
  // Reset source combination
  // --------------------------------
  wire src_pin;
  wire src_drop;
  wire any_src;
  assign src_pin = boot_taken && !boot_sel && !ext_n_s;
  assign src_drop = boot_taken && boot_sel && drop_s;
  assign any_src = !power_on_n || src_pin || src_drop || wd_over;

  always @(posedge aclk) begin
    if (!aresetn) begin
      boot_sel <= 1'b0;
      boot_taken <= 1'b0;
    end else if (!boot_taken) begin
      boot_sel <= boot_option_internal;
      boot_taken <= 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt <= 5'h00;
      system_reset_n <= 1'b0;
      reset_pin_low_active <= 1'b0;
      reset_pin_oe_n <= 1'b0;
    end else if (any_src) begin
      hold_cnt <= 5'h00;
      system_reset_n <= 1'b0;
      reset_pin_low_active <= 1'b0;
      reset_pin_oe_n <= 1'b0;
    end else if (hold_cnt != `RSM_HOLD_CYC) begin
      hold_cnt <= hold_cnt + 5'h01;
    end else begin
      system_reset_n <= 1'b1;
      reset_pin_low_active <= 1'b1;
      reset_pin_oe_n <= 1'b1;
    end
  end

  // --------------------------------
  // Bus slave
  // --------------------------------
  reg [4:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  wire do_write;
  assign do_write = aw_have && w_have && !s_axi_bvalid;
  wire [2:0] w1c;
  assign w1c = (do_write && aw_addr == `RSM_OFS_STS && w_strb[0]) ? w_data[2:0] : 3'h0;
  reg [2:0] ev;
  always @* begin
    ev = 3'h0;
    ev[`RSM_ST_LOW] = low_s && supply_detect_control[`RSM_SDC_EN];
    ev[`RSM_ST_WDT] = wd_over;
    ev[`RSM_ST_DROP] = src_drop;
  end

  always @(posedge aclk) begin
    if (!aresetn || !system_reset_n) begin
      supply_detect_control <= `RSM_SDC_RST;
      basic_timer_control <= `RSM_BTC_RST;
      mask <= `RSM_MSK_RST;
      detect_threshold <= 2'h0;
      detector_enable <= 1'b0;
    end else begin
      supply_detect_control[`RSM_SDC_FLAG] <= low_s && supply_detect_control[`RSM_SDC_EN];
      detector_enable <= supply_detect_control[`RSM_SDC_EN];
      detect_threshold <= supply_detect_control[`RSM_SDC_LVL_HI:`RSM_SDC_LVL_LO];
      if (do_write && w_strb[0]) begin
        case (aw_addr)
          `RSM_OFS_SDC: begin
            supply_detect_control[7:6] <= w_data[7:6];
            supply_detect_control[4:0] <= w_data[4:0];
          end
          `RSM_OFS_BTC: basic_timer_control <= w_data[7:0];
          `RSM_OFS_MSK: mask <= w_data[2:0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status <= 3'h0;
      last_cause <= 2'h0;
      wd_refresh <= 1'b0;
      irq <= 1'b0;
    end else begin
      status <= (status & ~w1c) | ev;
      wd_refresh <= do_write && w_strb[0] && aw_addr == `RSM_OFS_BTC && w_data[`RSM_BTC_CLR];
      if (wd_over) last_cause <= 2'h1;
      else if (src_drop) last_cause <= 2'h2;
      else if (src_pin) last_cause <= 2'h3;
      irq <= |(((status & ~w1c) | ev) & mask &
        {2'h3, supply_detect_control[`RSM_SDC_IE]});
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready;
      s_axi_wready <= !w_have && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `RSM_OFS_CAU || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `RSM_OFS_SDC: s_axi_rdata <= {24'h000000, supply_detect_control};
          `RSM_OFS_BTC: s_axi_rdata <= {24'h000000, basic_timer_control};
          `RSM_OFS_STS: s_axi_rdata <= {29'h00000000, status};
          `RSM_OFS_MSK: s_axi_rdata <= {29'h00000000, mask};
          `RSM_OFS_CAU: s_axi_rdata <= {29'h00000000, boot_sel, last_cause};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rsm_top
`default_nettype wire

// >>> verification/rsm_chk.sv
// Assertion checker for the reset and supply monitor
`timescale 1ns/1ps
`default_nettype none
module rsm_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on_n,
  input wire logic external_reset_n,
  input wire logic supply_drop_reset,
  input wire logic supply_level_detector,
  input wire logic boot_option_internal,
  input wire logic system_reset_n,
  input wire logic reset_pin_low_active,
  input wire logic reset_pin_oe_n,
  input wire logic irq,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_PIN_LOW: assert property (!system_reset_n |-> !reset_pin_oe_n && !reset_pin_low_active)
    else $error("pin not driven low in reset");
  AST_EXT_SYNC: assert property ($fell(external_reset_n) && system_reset_n |=> system_reset_n)
    else $error("pin reset not synchronized");
  AST_EXT_RST: assert property (!boot_option_internal && !external_reset_n [*5] |-> !system_reset_n)
    else $error("pin reset missed");
  AST_POR: assert property (!power_on_n [*5] |-> !system_reset_n)
    else $error("power-on reset missed");
  AST_DROP_RST: assert property (boot_option_internal && supply_drop_reset [*5] |-> !system_reset_n)
    else $error("supply drop reset missed");
  AST_DROP_OFF: assert property (system_reset_n && !boot_option_internal && $rose(supply_drop_reset)
    |=> system_reset_n [*4])
    else $error("drop reset used while pin selected");
  AST_DROP_REL: assert property ($rose(system_reset_n) && boot_option_internal
    |-> !$past(supply_drop_reset, 16))
    else $error("released while supply low");
  AST_LVD_SYNC: assert property ($rose(supply_level_detector) && !irq |=> !irq [*2])
    else $error("detector not synchronized");
  cover property ($fell(system_reset_n));
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // rsm_chk
bind rsm_top rsm_chk u_rsm_chk (.aclk, .aresetn, .power_on_n, .external_reset_n,
  .supply_drop_reset, .supply_level_detector, .boot_option_internal, .system_reset_n,
  .reset_pin_low_active, .reset_pin_oe_n, .irq, .s_axi_rvalid, .s_axi_rresp);
`default_nettype wire

// >>> verification/rsm_partner.sv
// Pin driver and supply comparators outside the monitor
`timescale 1ns/1ps
`default_nettype none
module rsm_partner #(
  parameter int PW = 20
) (
  input wire logic clk,
  input wire logic [3:0] want,
  output logic power_on_n,
  output logic external_reset_n,
  output logic supply_drop_reset,
  output logic supply_level_detector
);
  int cnt = 0;
  always @(posedge clk) begin
    if (!want[0]) cnt <= 0;
    else if (cnt < PW) cnt <= cnt + 1;
  end
  assign power_on_n = want[0];
  assign external_reset_n = want[1] && (cnt >= PW);
  assign supply_drop_reset = want[2];
  assign supply_level_detector = want[3];
endmodule // rsm_partner
`default_nettype wire

// >>> verification/rsm_top_tb_top.sv
// Testbench for the reset and supply monitor
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defs.vh"
module rsm_top_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, boot_option_internal = 1'h0;
  logic power_on_n, external_reset_n, supply_drop_reset, supply_level_detector;
  logic [3:0] want = 4'h3, s_axi_wstrb = 4'hF;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, detect_threshold;
  logic reset_pin_low_active, reset_pin_oe_n, system_reset_n, detector_enable, irq;
  int error_cnt = 0, compares = 0, cyc = 0, n = 0;
  rsm_top u_rsm_top (.aclk, .aresetn, .power_on_n, .external_reset_n, .supply_drop_reset,
    .supply_level_detector, .boot_option_internal, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_low_active,
    .reset_pin_oe_n, .system_reset_n, .detect_threshold, .detector_enable, .irq);
  rsm_partner u_rsm_partner (.clk(aclk), .want, .power_on_n, .external_reset_n,
    .supply_drop_reset, .supply_level_detector);
  initial begin
    forever #25 aclk = ~aclk;
  end
  task end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      end_sim;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task rdc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'h0;
    chk(d, e);
  endtask
  task wait_up;
    while (system_reset_n !== 1'h1) @(posedge aclk);
  endtask
  task idle(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task rst_run;
    aresetn <= 1'h0;
    idle(12);
    aresetn <= 1'h1;
    wait_up;
    wr(`RSM_OFS_BTC, 32'hA0);
  endtask
  initial begin
    rst_run;
    rdc(`RSM_OFS_SDC, 32'h0, 2'h0);
    rdc(`RSM_OFS_MSK, 32'h0, 2'h0);
    rdc(`RSM_OFS_BTC, 32'hA0, 2'h0);
    rdc(5'h14, 32'h0, 2'h2);
    rdc(5'h02, 32'h0, 2'h2);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(`RSM_OFS_SDC, 32'h90 + i);
      idle(2);
      chk(detect_threshold, i);
      chk(detector_enable, 1'h1);
    end
    wr(`RSM_OFS_MSK, 32'h1);
    want[3] <= 1'h1;
    idle(6);
    rdc(`RSM_OFS_SDC, 32'hB3, 2'h0);
    chk(irq, 1'h1);
    wr(`RSM_OFS_MSK, 32'h0);
    idle(2);
    chk(irq, 1'h0);
    wr(`RSM_OFS_MSK, 32'h1);
    want[3] <= 1'h0;
    idle(6);
    rdc(`RSM_OFS_SDC, 32'h93, 2'h0);
    chk(irq, 1'h1);
    wr(`RSM_OFS_STS, 32'h1);
    idle(2);
    chk(irq, 1'h0);
    rdc(`RSM_OFS_STS, 32'h0, 2'h0);
    wr(`RSM_OFS_SDC, 32'h13);
    idle(2);
    chk(detector_enable, 1'h0);
    want[3] <= 1'h1;
    idle(6);
    rdc(`RSM_OFS_SDC, 32'h13, 2'h0);
    chk(irq, 1'h0);
    want[3] <= 1'h0;
    idle(6);
    $display("test detector done");
    want[1] <= 1'h0;
    idle(8);
    chk(system_reset_n, 1'h0);
    chk(reset_pin_oe_n, 1'h0);
    want[1] <= 1'h1;
    wait_up;
    want[0] <= 1'h0;
    idle(8);
    chk(system_reset_n, 1'h0);
    want[0] <= 1'h1;
    idle(24);
    chk(system_reset_n, 1'h0);
    wait_up;
    rdc(`RSM_OFS_SDC, 32'h0, 2'h0);
    wr(`RSM_OFS_BTC, 32'hA0);
    want[2] <= 1'h1;
    idle(8);
    chk(system_reset_n, 1'h1);
    want[2] <= 1'h0;
    $display("test pin reset done");
    boot_option_internal <= 1'h1;
    rst_run;
    want[1] <= 1'h0;
    idle(8);
    chk(system_reset_n, 1'h1);
    want[1] <= 1'h1;
    want[2] <= 1'h1;
    idle(30);
    chk(system_reset_n, 1'h0);
    want[2] <= 1'h0;
    idle(10);
    chk(system_reset_n, 1'h0);
    wait_up;
    wr(`RSM_OFS_BTC, 32'hA0);
    rdc(`RSM_OFS_STS, 32'h4, 2'h0);
    wr(`RSM_OFS_STS, 32'h7);
    $display("test drop reset done");
    wr(`RSM_OFS_BTC, 32'h2);
    while (system_reset_n === 1'h1) begin
      @(posedge aclk);
      n++;
    end
    chk(n > 65500, 1'h1);
    wait_up;
    rdc(`RSM_OFS_STS, 32'h2, 2'h0);
    $display("test watchdog done");
    end_sim;
  end
endmodule // rsm_top_tb_top
`default_nettype wire
